// File: verilog/rkci_pkg.sv
package rkci_pkg;

    // ==========================================
    // control characters and command letters
    localparam logic [7:0] RKCI_ESC = 8'h1B;
    localparam logic [7:0] RKCI_CR = 8'h0D;
    localparam logic [7:0] RKCI_LF = 8'h0A;
    localparam logic [7:0] RKCI_STX = 8'h02;
    localparam logic [7:0] RKCI_ACK = 8'h06;
    localparam logic [7:0] RKCI_NAK = 8'h15;
    localparam logic [7:0] RKCI_XON = 8'h11;
    localparam logic [7:0] RKCI_XOFF = 8'h13;
    localparam logic [7:0] RKCI_ZERO = 8'h30;
    localparam logic [7:0] RKCI_NINE = 8'h39;
    localparam logic [7:0] RKCI_CLS_KEY = 8'h54;
    localparam logic [7:0] RKCI_CLS_OUT = 8'h41;
    localparam logic [7:0] RKCI_CLS_FUN = 8'h46;
    localparam logic [7:0] RKCI_CLS_SPC = 8'h53;

    // ==========================================
    // command codes, four bcd digits
    localparam logic [15:0] RKCI_KEY_DIG_MAX = 16'h0009;
    localparam logic [15:0] RKCI_KEY_EXT_MIN = 16'h0100;
    localparam logic [15:0] RKCI_KEY_EXT_MAX = 16'h0110;
    localparam logic [15:0] RKCI_OUT_ID = 16'h0000;
    localparam logic [15:0] RKCI_OUT_DPOS = 16'h0100;
    localparam logic [15:0] RKCI_OUT_APOS = 16'h0200;
    localparam logic [15:0] RKCI_OUT_ERR = 16'h0301;
    localparam logic [15:0] RKCI_OUT_SWID = 16'h0400;
    localparam logic [15:0] RKCI_OUT_SBAR = 16'h0800;
    localparam logic [15:0] RKCI_OUT_SIND = 16'h0900;
    localparam logic [15:0] RKCI_FUN_REF = 16'h0000;
    localparam logic [15:0] RKCI_FUN_PRINT = 16'h0002;
    localparam logic [15:0] RKCI_SPC_RESET = 16'h0000;
    localparam logic [15:0] RKCI_SPC_LOCK = 16'h0001;
    localparam logic [15:0] RKCI_SPC_FREE = 16'h0002;
    localparam logic [4:0] RKCI_KEY_EXT_BASE = 5'h0A;
    localparam logic [2:0] RKCI_PAGE_LOCKED = 3'h4;

    // ==========================================
    // receive buffer and response line lengths
    localparam logic [6:0] RKCI_BUF_DEPTH = 7'h64;
    localparam logic [5:0] RKCI_LEN_ID = 6'h0A;
    localparam logic [5:0] RKCI_LEN_APOS = 6'h0B;
    localparam logic [5:0] RKCI_LEN_ERR = 6'h23;
    localparam logic [5:0] RKCI_LEN_SWID = 6'h0A;
    localparam logic [5:0] RKCI_LEN_SBAR = 6'h08;
    localparam logic [5:0] RKCI_LEN_SIND = 6'h0C;
    localparam logic [1:0] RKCI_ID_LINES = 2'h3;

    // ==========================================
    // register map
    localparam logic [1:0] RKCI_REG_CTRL = 2'h0;
    localparam logic [1:0] RKCI_REG_STAT = 2'h1;
    localparam logic [1:0] RKCI_REG_COUNT = 2'h2;
    localparam logic RKCI_CTRL_RESET = 1'b1;

    typedef enum logic [3:0] {
        RK_ACK, RK_NAK, RK_ID, RK_DPOS, RK_APOS, RK_ERR, RK_SWID, RK_SBAR, RK_SIND
    } rkci_resp_t;

    typedef struct packed {
        logic op_mode;
        logic scaling;
        logic comp;
        logic stopwatch;
        logic [2:0] unit;
        logic [1:0] datum;
        logic [1:0] page;
    } rkci_sbar_t;

endpackage

// File: verilog/rkci_top.sv
// The plain strobed port and the register addresses were left to the implementer.
`timescale 1ns/10ps
module rkci_top
    import rkci_pkg::*;
#(
    parameter logic [79:0] DEV_NAME = "  DEVICE-0",  // arbitrary value
    parameter logic [79:0] SW_ID = " 000000-00",     // arbitrary value
    parameter logic [79:0] SW_VER = "     V0-00"     // arbitrary value
) (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // received characters from the uart
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    // characters to the uart
    output logic tx_valid,
    output logic [7:0] tx_data,
    input wire logic tx_ready,
    // display state shown in answers
    input wire logic [103:0] disp_text,
    input wire logic [3:0] disp_len,
    input wire logic [87:0] act_pos,
    input wire logic err_shown,
    input wire logic [279:0] err_text,
    input wire rkci_sbar_t sbar,
    input wire logic [1:0] set_ind,
    // actions
    output logic key_valid,
    output logic [4:0] key_code,
    output logic print_req,
    output logic display_reset,
    output logic ref_mode,
    output logic keypad_locked,
    // register port
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata
);

    typedef enum logic [2:0] {
        ST_HUNT, ST_CLASS, ST_DIGIT, ST_END, ST_DECIDE, ST_SEND, ST_DRAIN
    } rkci_state_t;

    // ==========================================
    // receive buffer
    logic [7:0] buf_mem [RKCI_BUF_DEPTH];
    logic [6:0] wr_ptr;
    logic [6:0] rd_ptr;
    logic [6:0] count;
    logic rx_enable;
    rkci_state_t state;

    wire buf_full = (count == RKCI_BUF_DEPTH);
    wire buf_empty = (count == 7'h00);
    wire push = rx_valid && rx_enable && !buf_full;
    wire parsing = (state == ST_HUNT) || (state == ST_CLASS) || (state == ST_DIGIT) || (state == ST_END);
    wire pop = parsing && !buf_empty;
    wire [7:0] ch = buf_mem[rd_ptr];
    wire [6:0] next_wr_ptr = (wr_ptr == RKCI_BUF_DEPTH - 7'h01) ? 7'h00 : wr_ptr + 7'h01;
    wire [6:0] next_rd_ptr = (rd_ptr == RKCI_BUF_DEPTH - 7'h01) ? 7'h00 : rd_ptr + 7'h01;

    always_ff @(posedge clk) begin
        if (push) begin
            buf_mem[wr_ptr] <= rx_data;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            wr_ptr <= 7'h00;
            rd_ptr <= 7'h00;
            count <= 7'h00;
        end else begin
            if (push) begin
                wr_ptr <= next_wr_ptr;
            end
            if (pop) begin
                rd_ptr <= next_rd_ptr;
            end
            count <= count + {6'h00, push} - {6'h00, pop};
        end
    end

    // ==========================================
    // flow control
    logic xoff_sent;
    logic xoff_pend;
    logic xon_pend;
    wire tx_free = !tx_valid || tx_ready;
    wire flow_pend = xoff_pend || xon_pend;
    wire load_flow = tx_free && flow_pend;

    always_ff @(posedge clk) begin
        if (srst) begin
            xoff_sent <= 1'b0;
            xoff_pend <= 1'b0;
            xon_pend <= 1'b0;
        end else if (load_flow) begin
            xoff_sent <= xoff_pend;
            xoff_pend <= 1'b0;
            xon_pend <= 1'b0;
        end else if (buf_full && !xoff_sent && !xoff_pend) begin
            xoff_pend <= 1'b1;
        end else if (xoff_sent && buf_empty && !xon_pend) begin
            // a frame cut by xoff can only finish once the host resumes
            xon_pend <= 1'b1;
        end
    end

    // ==========================================
    // frame parser
    logic [7:0] cls;
    logic [15:0] code;
    logic [1:0] dig_cnt;
    logic bad;
    wire is_digit = (ch >= RKCI_ZERO) && (ch <= RKCI_NINE);

    // ==========================================
    // command decode
    wire is_key = (cls == RKCI_CLS_KEY);
    wire is_out = (cls == RKCI_CLS_OUT);
    wire is_fun = (cls == RKCI_CLS_FUN);
    wire is_spc = (cls == RKCI_CLS_SPC);
    wire key_ok = is_key && (code <= RKCI_KEY_DIG_MAX ||
                  (code >= RKCI_KEY_EXT_MIN && code <= RKCI_KEY_EXT_MAX));
    wire [4:0] key_ext = code[4] ? RKCI_KEY_EXT_BASE + 5'h0A : RKCI_KEY_EXT_BASE + {1'b0, code[3:0]};
    wire [4:0] key_idx = (code[15:8] == 8'h00) ? {1'b0, code[3:0]} : key_ext;
    wire fun_ok = is_fun && (code == RKCI_FUN_REF || code == RKCI_FUN_PRINT);
    wire spc_ok = is_spc && (code == RKCI_SPC_RESET || code == RKCI_SPC_LOCK || code == RKCI_SPC_FREE);
    rkci_resp_t out_kind;
    logic out_ok;

    always_comb begin
        out_ok = is_out;
        out_kind = RK_NAK;
        unique case (code)
            RKCI_OUT_ID: out_kind = RK_ID;
            RKCI_OUT_DPOS: out_kind = RK_DPOS;
            RKCI_OUT_APOS: out_kind = RK_APOS;
            RKCI_OUT_ERR: begin
                out_kind = RK_ERR;
                out_ok = is_out && err_shown;
            end
            RKCI_OUT_SWID: out_kind = RK_SWID;
            RKCI_OUT_SBAR: out_kind = RK_SBAR;
            RKCI_OUT_SIND: out_kind = RK_SIND;
            default: out_ok = 1'b0;
        endcase
    end

    wire rkci_resp_t decided = bad ? RK_NAK : (out_ok ? out_kind :
        ((key_ok || fun_ok || spc_ok) ? RK_ACK : RK_NAK));

    // ==========================================
    // response text selection
    rkci_resp_t kind;
    logic [1:0] line;
    logic [5:0] col;
    logic stx_sent;
    logic [5:0] len;
    logic [1:0] n_lines;
    logic [279:0] sel_text;
    wire [2:0] page_dig = keypad_locked ? RKCI_PAGE_LOCKED : {1'b0, sbar.page};
    wire [63:0] sbar_text = {RKCI_ZERO + {7'h00, sbar.op_mode}, RKCI_ZERO, RKCI_ZERO + {7'h00, sbar.scaling},
        RKCI_ZERO + {7'h00, sbar.comp}, RKCI_ZERO + {7'h00, sbar.stopwatch}, RKCI_ZERO + {5'h00, sbar.unit},
        RKCI_ZERO + {6'h00, sbar.datum}, RKCI_ZERO + {5'h00, page_dig}};
    wire [95:0] sind_text = {{9{RKCI_ZERO}}, RKCI_ZERO + {6'h00, set_ind},
        RKCI_ZERO + {7'h00, ref_mode}, RKCI_ZERO};
    wire [79:0] id_line = (line == 2'h0) ? DEV_NAME : ((line == 2'h1) ? SW_ID : SW_VER);

    always_comb begin
        len = RKCI_LEN_ID;
        n_lines = 2'h1;
        sel_text = '0;
        unique case (kind)
            RK_ID: begin
                n_lines = RKCI_ID_LINES;
                sel_text = {200'h0, id_line};
            end
            RK_DPOS: begin
                len = {2'b00, disp_len};
                sel_text = {176'h0, disp_text};
            end
            RK_APOS: begin
                len = RKCI_LEN_APOS;
                sel_text = {192'h0, act_pos};
            end
            RK_ERR: begin
                len = RKCI_LEN_ERR;
                sel_text = err_text;
            end
            RK_SWID: begin
                len = RKCI_LEN_SWID;
                sel_text = {200'h0, SW_ID};
            end
            RK_SBAR: begin
                len = RKCI_LEN_SBAR;
                sel_text = {216'h0, sbar_text};
            end
            RK_SIND: begin
                len = RKCI_LEN_SIND;
                sel_text = {184'h0, sind_text};
            end
            default: begin
                len = RKCI_LEN_ID;
            end
        endcase
    end

    wire single = (kind == RK_ACK) || (kind == RK_NAK);
    wire [5:0] rev_col = len - 6'h01 - col;
    wire [8:0] bit_ofs = {rev_col, 3'b000};
    wire at_cr = (col == len);
    wire at_lf = (col == len + 6'h01);
    wire [7:0] resp_char = (kind == RK_ACK) ? RKCI_ACK : (kind == RK_NAK) ? RKCI_NAK :
        !stx_sent ? RKCI_STX : at_cr ? RKCI_CR : at_lf ? RKCI_LF : sel_text[bit_ofs +: 8];
    wire resp_last = single || (stx_sent && at_lf && line == n_lines - 2'h1);
    wire load_resp = tx_free && !flow_pend && (state == ST_SEND);

    // ==========================================
    // sequencer
    always_ff @(posedge clk) begin
        if (srst) begin
            state <= ST_HUNT;
            cls <= 8'h00;
            code <= 16'h0000;
            dig_cnt <= 2'h0;
            bad <= 1'b0;
            kind <= RK_NAK;
            line <= 2'h0;
            col <= 6'h00;
            stx_sent <= 1'b0;
        end else begin
            unique case (state)
                ST_HUNT: begin
                    if (pop && ch == RKCI_ESC) begin
                        state <= ST_CLASS;
                    end
                end
                ST_CLASS: begin
                    if (pop) begin
                        cls <= ch;
                        bad <= 1'b0;
                        dig_cnt <= 2'h0;
                        state <= ST_DIGIT;
                    end
                end
                ST_DIGIT: begin
                    if (pop) begin
                        code <= {code[11:0], ch[3:0]};
                        bad <= bad || !is_digit;
                        dig_cnt <= dig_cnt + 2'h1;
                        if (dig_cnt == 2'h3) begin
                            state <= ST_END;
                        end
                    end
                end
                ST_END: begin
                    if (pop) begin
                        bad <= bad || (ch != RKCI_CR);
                        state <= ST_DECIDE;
                    end
                end
                ST_DECIDE: begin
                    kind <= decided;
                    line <= 2'h0;
                    col <= 6'h00;
                    stx_sent <= 1'b0;
                    state <= ST_SEND;
                end
                ST_SEND: begin
                    if (load_resp) begin
                        if (resp_last) begin
                            state <= ST_DRAIN;
                        end else if (!stx_sent) begin
                            stx_sent <= 1'b1;
                        end else if (at_lf) begin
                            col <= 6'h00;
                            line <= line + 2'h1;
                        end else begin
                            col <= col + 6'h01;
                        end
                    end
                end
                ST_DRAIN: begin
                    if (tx_free) begin
                        state <= ST_HUNT;
                    end
                end
                default: begin
                    state <= ST_HUNT;
                end
            endcase
        end
    end

    // ==========================================
    // transmit register and actions
    // actions fire only once the answer byte has left the register
    wire act_now = (state == ST_DRAIN) && tx_free && (kind == RK_ACK);

    always_ff @(posedge clk) begin
        if (srst) begin
            tx_valid <= 1'b0;
            tx_data <= 8'h00;
        end else if (load_flow) begin
            tx_valid <= 1'b1;
            tx_data <= xoff_pend ? RKCI_XOFF : RKCI_XON;
        end else if (load_resp) begin
            tx_valid <= 1'b1;
            tx_data <= resp_char;
        end else if (tx_ready) begin
            tx_valid <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            key_valid <= 1'b0;
            key_code <= 5'h00;
            print_req <= 1'b0;
            display_reset <= 1'b0;
            ref_mode <= 1'b0;
            keypad_locked <= 1'b0;
        end else begin
            key_valid <= act_now && is_key;
            print_req <= act_now && is_fun && code == RKCI_FUN_PRINT;
            display_reset <= act_now && is_spc && code == RKCI_SPC_RESET;
            if (act_now && is_key) begin
                key_code <= key_idx;
            end
            if (act_now && is_fun && code == RKCI_FUN_REF) begin
                ref_mode <= !ref_mode;
            end
            if (act_now && is_spc && code == RKCI_SPC_LOCK) begin
                keypad_locked <= 1'b1;
            end else if (act_now && is_spc && code != RKCI_SPC_LOCK) begin
                keypad_locked <= 1'b0;
            end
        end
    end

    // ==========================================
    // register port
    wire [7:0] stat_word = {4'h0, keypad_locked, ref_mode, xoff_sent, buf_full};
    wire [7:0] rd_mux = (reg_addr == RKCI_REG_CTRL) ? {7'h00, rx_enable} :
        (reg_addr == RKCI_REG_STAT) ? stat_word : (reg_addr == RKCI_REG_COUNT) ? {1'b0, count} : 8'h00;

    always_ff @(posedge clk) begin
        if (srst) begin
            rx_enable <= RKCI_CTRL_RESET;
            reg_rdata <= 8'h00;
        end else begin
            if (reg_wr && reg_addr == RKCI_REG_CTRL) begin
                rx_enable <= reg_wdata[0];
            end
            reg_rdata <= reg_rd ? rd_mux : 8'h00;
        end
    end

    // ==========================================
    // checks
    chk_buf_bound: assert property (@(posedge clk) disable iff (srst) count <= RKCI_BUF_DEPTH)
        else $error("receive buffer count above depth");
    chk_full_drop: assert property (@(posedge clk) disable iff (srst)
        buf_full && rx_valid && !pop |=> buf_full && wr_ptr == $past(wr_ptr))
        else $error("full buffer accepted a character");
    chk_xoff_full: assert property (@(posedge clk) disable iff (srst)
        $rose(buf_full) && !xoff_sent |=> xoff_pend || xoff_sent)
        else $error("no xoff raised on full buffer");
    chk_xoff_first: assert property (@(posedge clk) disable iff (srst)
        xoff_pend && tx_free |=> tx_valid && tx_data == RKCI_XOFF)
        else $error("xoff not loaded when pending");
    chk_ack_key: assert property (@(posedge clk) disable iff (srst)
        key_valid |-> $past(state == ST_DRAIN && kind == RK_ACK && tx_free))
        else $error("key action without prior ack");
    chk_nak_quiet: assert property (@(posedge clk) disable iff (srst)
        state == ST_DRAIN && kind == RK_NAK |=> !key_valid && !print_req && !display_reset)
        else $error("action after nak");
    chk_crlf_pair: assert property (@(posedge clk) disable iff (srst)
        load_resp && !single && stx_sent && at_cr |=> state == ST_SEND && resp_char == RKCI_LF)
        else $error("cr not followed by lf");
    chk_lock_ack: assert property (@(posedge clk) disable iff (srst)
        $rose(keypad_locked) |-> $past(kind == RK_ACK && state == ST_DRAIN))
        else $error("keypad locked without ack");
    chk_hunt_esc: assert property (@(posedge clk) disable iff (srst)
        state == ST_HUNT && pop && ch != RKCI_ESC |=> state == ST_HUNT)
        else $error("parser left hunt without escape");

endmodule

// File: bench/rkci_host.sv
`timescale 1ns/10ps
module rkci_host
    import rkci_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // device transmit side
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    output logic tx_ready,
    // device receive side
    output logic rx_valid,
    output logic [7:0] rx_data
);
    // ====================
    // host queues, filled and emptied by the bench
    logic [7:0] txq[$];
    logic [7:0] rxq[$];
    logic paused = 1'b0;
    logic stall = 1'b0;
    logic slow = 1'b0;

    initial begin
        tx_ready = 1'b0;
        rx_valid = 1'b0;
        rx_data = 8'h00;
    end

    always @(posedge clk) begin
        if (tx_valid && tx_ready) begin
            rxq.push_back(tx_data);
            if (tx_data === RKCI_XOFF) paused = 1'b1;
            if (tx_data === RKCI_XON) paused = 1'b0;
        end
        tx_ready <= !stall && (!slow || $urandom_range(1) == 1);
        if (!srst && !paused && txq.size() > 0) begin
            rx_valid <= 1'b1;
            rx_data <= txq.pop_front();
        end else begin
            rx_valid <= 1'b0;
            // idle line inverts its data every cycle rather than holding the last character
            rx_data <= ~rx_data;
        end
    end
endmodule

// File: bench/rkci_top_tb.sv
`timescale 1ns/10ps
module rkci_top_tb;
    import rkci_pkg::*;
    localparam logic [79:0] NAME = "  TESTER-1"; // arbitrary value
    localparam logic [79:0] SWID = " 123456-78"; // arbitrary value
    localparam logic [79:0] SWVER = "     V9-87"; // arbitrary value
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic rx_valid, tx_valid, tx_ready, key_valid, print_req, display_reset, ref_mode, keypad_locked;
    logic [7:0] rx_data, tx_data, reg_rdata;
    logic [7:0] reg_wdata = 8'h00;
    logic [103:0] disp_text = '0;
    logic [3:0] disp_len = 4'hA;
    logic [87:0] act_pos = '0;
    logic err_shown = 1'b0;
    logic [279:0] err_text = '0;
    rkci_sbar_t sbar = '0;
    logic [1:0] set_ind = 2'h0;
    logic [4:0] key_code, last_key;
    logic [1:0] reg_addr = 2'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    int errors = 0;
    int n_tests = 0;
    int n_key = 0;
    int n_print = 0;
    int n_dreset = 0;
    logic [7:0] exp[$];
    logic [7:0] q[$];
    logic [15:0] bad_keys[4] = '{16'h0010, 16'h0099, 16'h0111, 16'h0A00};

    always #10 clk = ~clk;

    rkci_top #(.DEV_NAME(NAME), .SW_ID(SWID), .SW_VER(SWVER)) i_rkci_top (.clk, .srst, .rx_valid, .rx_data,
        .tx_valid, .tx_data, .tx_ready, .disp_text, .disp_len, .act_pos, .err_shown, .err_text, .sbar,
        .set_ind, .key_valid, .key_code, .print_req, .display_reset, .ref_mode, .keypad_locked,
        .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
    rkci_host i_rkci_host (.clk, .srst, .tx_valid, .tx_data, .tx_ready, .rx_valid, .rx_data);

    // ====================
    // checking helpers
    task automatic tally_and_finish;
        if (errors == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic ok, input string m);
        n_tests++;
        if (ok !== 1'b1) begin
            errors++;
            $display("[ERR] %0t %s", $time, m);
        end
    endtask

    always @(posedge clk) begin
        if (key_valid === 1'b1) begin
            n_key++;
            last_key = key_code;
            chk(i_rkci_host.rxq.size() > 0, "key action before ack");
        end
        if (print_req === 1'b1) n_print++;
        if (display_reset === 1'b1) n_dreset++;
    end

    function automatic logic [15:0] keyc(input int i);
        return i < 10 ? 16'(i) : (i < 20 ? 16'h0100 + 16'(i - 10) : 16'h0110);
    endfunction

    function automatic logic [63:0] sbar_exp(input rkci_sbar_t s, input logic lk);
        return {8'h30 | s.op_mode, 8'h30, 8'h30 | s.scaling, 8'h30 | s.comp, 8'h30 | s.stopwatch,
            8'h30 | s.unit, 8'h30 | s.datum, lk ? 8'h34 : (8'h30 | s.page)};
    endfunction

    // ====================
    // host and register traffic
    task automatic send(input logic [7:0] c, input logic [15:0] code, input logic [7:0] term);
        i_rkci_host.txq.push_back(RKCI_ESC);
        i_rkci_host.txq.push_back(c);
        for (int i = 3; i >= 0; i--) i_rkci_host.txq.push_back(8'h30 + 8'(code[4*i +: 4]));
        i_rkci_host.txq.push_back(term);
    endtask

    task automatic put(input logic [279:0] v, input int n);
        for (int i = n - 1; i >= 0; i--) exp.push_back(v[8*i +: 8]);
    endtask

    task automatic expect_rx(input string m);
        int k = 0;
        while (i_rkci_host.rxq.size() < exp.size() && k < 3000) begin
            @(posedge clk);
            k++;
        end
        if (k == 3000) begin
            chk(1'b0, "answer timeout");
            tally_and_finish();
        end
        repeat (30) @(posedge clk);
        chk(i_rkci_host.rxq == exp, m);
        i_rkci_host.rxq.delete();
        exp.delete();
    endtask

    task automatic reply(input logic [7:0] c, input logic [15:0] code, input logic [7:0] r, input string m);
        send(c, code, RKCI_CR);
        exp.push_back(r);
        expect_rx(m);
    endtask

    task automatic outq(input logic [15:0] code);
        send(RKCI_CLS_OUT, code, RKCI_CR);
        exp.push_back(RKCI_STX);
    endtask

    task automatic fin(input string m);
        exp.push_back(RKCI_CR);
        exp.push_back(RKCI_LF);
        expect_rx(m);
    endtask

    task automatic key(input int d, input logic bad);
        int nk = n_key;
        logic [15:0] code = keyc(d);
        if (bad) code[3:0] = 4'hB;
        reply(RKCI_CLS_KEY, code, bad ? RKCI_NAK : RKCI_ACK, "key answer");
        chk(n_key == nk + (bad ? 0 : 1) && (bad || last_key === 5'(d)), "key action");
    endtask

    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [1:0] a, input logic [7:0] e, input logic [7:0] msk);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk((reg_rdata & msk) === e, "register read");
    endtask

    // ====================
    // main sequence
    initial begin
        int k;
        void'($urandom(32'h5E14A743));
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        chk(tx_valid === 1'b0 && keypad_locked === 1'b0 && ref_mode === 1'b0, "reset outputs");
        rd(RKCI_REG_CTRL, 8'h01, 8'hFF);
        wr(RKCI_REG_STAT, 8'hFF);
        wr(2'h3, 8'hFF);
        rd(RKCI_REG_STAT, 8'h00, 8'hFF);
        rd(2'h3, 8'h00, 8'hFF);
        for (int i = 0; i < 21; i++) key(i, 1'b0);
        send(RKCI_CLS_KEY, 16'h0003, 8'h5A);
        exp.push_back(RKCI_NAK);
        expect_rx("missing terminator");
        foreach (bad_keys[j]) reply(RKCI_CLS_KEY, bad_keys[j], RKCI_NAK, "bad key");
        reply(RKCI_CLS_KEY, 16'h0010, RKCI_NAK, "bad key");
        reply(RKCI_CLS_KEY, 16'h0111, RKCI_NAK, "bad key");
        reply(RKCI_CLS_OUT, 16'h0500, RKCI_NAK, "bad output");
        reply(RKCI_CLS_FUN, RKCI_FUN_REF, RKCI_ACK, "ref toggle");
        chk(ref_mode === 1'b1, "ref mode");
        k = n_print;
        reply(RKCI_CLS_FUN, RKCI_FUN_PRINT, RKCI_ACK, "print");
        chk(n_print == k + 1, "print pulse");
        reply(RKCI_CLS_FUN, 16'h0001, RKCI_NAK, "bad function");
        @(posedge clk);
        // text kept above the flow characters so the host never pauses on it
        disp_text <= 104'({$urandom, $urandom, $urandom, $urandom}) | {13{8'h40}};
        disp_len <= 4'(10 + $urandom_range(3));
        act_pos <= 88'({$urandom, $urandom, $urandom}) | {11{8'h40}};
        err_text <= 280'({9{$urandom}}) | {35{8'h40}};
        err_shown <= 1'b1;
        set_ind <= 2'($urandom_range(2));
        sbar <= '{1'($urandom_range(1)), 1'($urandom_range(1)), 1'($urandom_range(1)), 1'($urandom_range(1)),
            3'($urandom_range(4)), 2'($urandom_range(2, 1)), 2'($urandom_range(3, 1))};
        @(posedge clk);
        outq(RKCI_OUT_ID);
        put(NAME, 10);
        exp.push_back(RKCI_CR);
        exp.push_back(RKCI_LF);
        put({SWID, RKCI_CR, RKCI_LF, SWVER}, 22);
        fin("identification");
        outq(RKCI_OUT_DPOS);
        put(disp_text, int'(disp_len));
        fin("displayed position");
        outq(RKCI_OUT_APOS);
        put(act_pos, 11);
        fin("actual position");
        outq(RKCI_OUT_ERR);
        put(err_text, 35);
        fin("error text");
        outq(RKCI_OUT_SWID);
        put(SWID, 10);
        fin("software id");
        outq(RKCI_OUT_SIND);
        put({{9{8'h30}}, 8'h30 | set_ind, 8'h31, 8'h30}, 12);
        fin("indicators");
        outq(RKCI_OUT_SBAR);
        put(sbar_exp(sbar, 1'b0), 8);
        fin("status bar");
        reply(RKCI_CLS_SPC, RKCI_SPC_LOCK, RKCI_ACK, "lock");
        chk(keypad_locked === 1'b1, "locked");
        rd(RKCI_REG_STAT, 8'h0C, 8'hFC);
        outq(RKCI_OUT_SBAR);
        put(sbar_exp(sbar, 1'b1), 8);
        fin("status bar locked");
        reply(RKCI_CLS_SPC, RKCI_SPC_FREE, RKCI_ACK, "release");
        chk(keypad_locked === 1'b0, "released");
        k = n_dreset;
        reply(RKCI_CLS_SPC, RKCI_SPC_RESET, RKCI_ACK, "display reset");
        chk(n_dreset == k + 1, "display reset pulse");
        reply(RKCI_CLS_SPC, 16'h0003, RKCI_NAK, "bad special");
        err_shown <= 1'b0;
        reply(RKCI_CLS_OUT, RKCI_OUT_ERR, RKCI_NAK, "no error shown");
        wr(RKCI_REG_CTRL, 8'h00);
        send(RKCI_CLS_KEY, 16'h0001, RKCI_CR);
        expect_rx("receiver disabled");
        wr(RKCI_REG_CTRL, 8'h01);
        // flood while the host refuses answers, buffer must saturate
        i_rkci_host.stall = 1'b1;
        k = n_key;
        send(RKCI_CLS_KEY, 16'h0005, RKCI_CR);
        repeat (110) i_rkci_host.txq.push_back(8'h78);
        for (int t = 0; t < 400 && i_rkci_host.txq.size() > 0; t++) @(posedge clk);
        chk(i_rkci_host.txq.size() == 0, "flood timeout");
        repeat (5) @(posedge clk);
        rd(RKCI_REG_COUNT, RKCI_BUF_DEPTH, 8'hFF);
        rd(RKCI_REG_STAT, 8'h01, 8'h01);
        i_rkci_host.stall = 1'b0;
        exp = '{RKCI_ACK, RKCI_XOFF, RKCI_XON};
        q = '{RKCI_XOFF, RKCI_ACK, RKCI_XON};
        for (int t = 0; t < 600 && i_rkci_host.rxq.size() < 3; t++) @(posedge clk);
        repeat (30) @(posedge clk);
        chk(i_rkci_host.rxq == exp || i_rkci_host.rxq == q, "flow control");
        chk(n_key == k + 1 && last_key === 5'h05, "key after flood");
        i_rkci_host.rxq.delete();
        exp.delete();
        rd(RKCI_REG_COUNT, 8'h00, 8'hFF);
        for (int i = 0; i < 30; i++) begin
            i_rkci_host.slow = 1'($urandom_range(1));
            if ($urandom_range(1) == 1) i_rkci_host.txq.push_back(8'h78);
            key($urandom_range(20), $urandom_range(3) == 0);
        end
        tally_and_finish();
    end
endmodule
